// File: src/pfs_pkg.sv
// package: register map, fields and timing of the flash row sequencer
package pfs_pkg;
  // -----------------------------------------
  // register offsets (byte addresses on the sfr bus)
  // -----------------------------------------
  localparam logic [15:0] OFS_CTRL = 16'h0760;
  localparam logic [15:0] OFS_ADRL = 16'h0762;
  localparam logic [15:0] OFS_ADRH = 16'h0764;
  localparam logic [15:0] OFS_KEY = 16'h0766;
  // -----------------------------------------
  // control register fields
  // -----------------------------------------
  localparam int BIT_START = 15;
  localparam int BIT_ALLOW = 14;
  localparam int BIT_ERR = 13;
  localparam int BIT_TERM = 8;
  localparam int OPSEL_W = 7;
  localparam logic [15:0] CTRL_IMPL = 16'he17f;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [6:0] OPSEL_ROW_ERASE = 7'h41;
  localparam logic [6:0] OPSEL_ROW_PROG = 7'h01;
  localparam logic [15:0] CTRL_ROW_ERASE = 16'h4041;
  // -----------------------------------------
  // unlock key and row geometry
  // -----------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int ROW_WORDS = 32;
  localparam int ROW_BYTES = 96;
  // -----------------------------------------
  // timing
  // -----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = (CLK_HZ / 1000000) * OP_TIME_US;
  // -----------------------------------------
  // key and operation sequencer states
  // -----------------------------------------
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT55 = 3'b010,
    KEY_ARMED = 3'b100
  } pfs_key_t;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_BUSY = 3'b010,
    SEQ_DONE = 3'b100
  } pfs_seq_t;
endpackage : pfs_pkg

// File: src/pfs_if.sv
// interface: sfr bus, table-write path and stall between core and sequencer
`timescale 1ns/1ps
`default_nettype none
interface pfs_if;
  logic sfrWr;
  logic sfrRd;
  logic [15:0] sfrAddr;
  logic [15:0] sfrWdata;
  logic [15:0] sfrRdata;
  logic tblValid;
  logic tblHigh;
  logic tblWrite;
  logic [23:0] tblAddr;
  logic [15:0] tblData;
  logic cpuStall;
  modport device (
    input sfrWr, sfrRd, sfrAddr, sfrWdata, tblValid, tblHigh, tblWrite, tblAddr, tblData,
    output sfrRdata, cpuStall
  );
  modport host (
    output sfrWr, sfrRd, sfrAddr, sfrWdata, tblValid, tblHigh, tblWrite, tblAddr, tblData,
    input sfrRdata, cpuStall
  );
endinterface : pfs_if
`default_nettype wire

// File: src/pfs_core_host.sv
// core end: issues register writes, table writes and the unlock sequence
`timescale 1ns/1ps
`default_nettype none
module pfs_core_host
  import pfs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  pfs_if.host bus,
  input wire logic reqRegWr,
  input wire logic reqRegRd,
  input wire logic reqUnlockStart,
  input wire logic reqTblWr,
  input wire logic reqTblHigh,
  input wire logic [23:0] reqAddr,
  input wire logic [15:0] reqData,
  output logic reqReady,
  output logic [15:0] rdData,
  output logic rdValid
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_KEY1 = 6'b000010,
    H_KEY2 = 6'b000100,
    H_START = 6'b001000,
    H_NOP = 6'b010000,
    H_WAIT = 6'b100000
  } pfs_host_t;

  pfs_host_t st_q;
  logic [15:0] ctrlShadow_q;
  logic nop_q;
  logic rdPend_q;
  logic sfrWr_q, sfrRd_q, tblValid_q, tblHigh_q;
  logic [15:0] sfrAddr_q, sfrWdata_q, tblData_q;
  logic [23:0] tblAddr_q;

  assign bus.sfrWr = sfrWr_q;
  assign bus.sfrRd = sfrRd_q;
  assign bus.sfrAddr = sfrAddr_q;
  assign bus.sfrWdata = sfrWdata_q;
  assign bus.tblValid = tblValid_q;
  assign bus.tblHigh = tblHigh_q;
  assign bus.tblWrite = tblValid_q;
  assign bus.tblAddr = tblAddr_q;
  assign bus.tblData = tblData_q;

  wire idleFree = (st_q == H_IDLE) && !bus.cpuStall;

  always_ff @(posedge clk) begin
    sfrWr_q <= 1'b0;
    sfrRd_q <= 1'b0;
    tblValid_q <= 1'b0;
    // device data lands a cycle after the strobe, so the valid flag waits one more
    rdPend_q <= sfrRd_q;
    rdValid <= rdPend_q;
    rdData <= bus.sfrRdata;
    if (sys_rst) begin
      st_q <= H_IDLE;
      ctrlShadow_q <= CTRL_RST;
      nop_q <= 1'b0;
      sfrAddr_q <= 16'h0000;
      sfrWdata_q <= 16'h0000;
      tblHigh_q <= 1'b0;
      tblAddr_q <= 24'h000000;
      tblData_q <= 16'h0000;
      reqReady <= 1'b0;
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      rdPend_q <= 1'b0;
    end else begin
      reqReady <= idleFree && !reqRegWr && !reqRegRd && !reqTblWr && !reqUnlockStart;
      case (st_q)
        H_IDLE: begin
          if (idleFree && reqRegWr) begin
            sfrWr_q <= 1'b1;
            sfrAddr_q <= reqAddr[15:0];
            sfrWdata_q <= reqData;
            if (reqAddr[15:0] == OFS_CTRL) begin
              ctrlShadow_q <= reqData;
            end
          end else if (idleFree && reqRegRd) begin
            sfrRd_q <= 1'b1;
            sfrAddr_q <= reqAddr[15:0];
          end else if (idleFree && reqTblWr) begin
            tblValid_q <= 1'b1;
            tblHigh_q <= reqTblHigh;
            tblAddr_q <= reqAddr;
            tblData_q <= reqData;
          end else if (idleFree && reqUnlockStart) begin
            st_q <= H_KEY1;
          end
        end
        H_KEY1: begin
          sfrWr_q <= 1'b1;
          sfrAddr_q <= OFS_KEY;
          sfrWdata_q <= {8'h00, KEY_FIRST};
          st_q <= H_KEY2;
        end
        H_KEY2: begin
          sfrWr_q <= 1'b1;
          sfrAddr_q <= OFS_KEY;
          sfrWdata_q <= {8'h00, KEY_SECOND};
          st_q <= H_START;
        end
        H_START: begin
          sfrWr_q <= 1'b1;
          sfrAddr_q <= OFS_CTRL;
          sfrWdata_q <= ctrlShadow_q | 16'h8000;
          nop_q <= 1'b0;
          st_q <= H_NOP;
        end
        H_NOP: begin
          nop_q <= 1'b1;
          if (nop_q) begin
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (!bus.cpuStall) begin
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule : pfs_core_host
`default_nettype wire

// File: src/pfs_row_sequencer.sv
// device end: flash row sequencer with address capture, key lock and latches
`timescale 1ns/1ps
`default_nettype none
module pfs_row_sequencer
  import pfs_pkg::*;
#(
  parameter int OP_CNT = OP_CYCLES
)(
  input wire logic clk,
  input wire logic sys_rst,
  pfs_if.device bus,
  output logic opBusy,
  output logic opDone,
  output logic opErase,
  output logic [23:0] opRowAddr,
  output logic [ROW_BYTES*8-1:0] rowImage,
  output logic [15:0] ctrlView
);
  // -----------------------------------------
  // decode
  // -----------------------------------------
  wire hitCtrl = bus.sfrAddr == OFS_CTRL;
  wire hitAdrL = bus.sfrAddr == OFS_ADRL;
  wire hitAdrH = bus.sfrAddr == OFS_ADRH;
  wire hitKey = bus.sfrAddr == OFS_KEY;
  wire wrCtrl = bus.sfrWr && hitCtrl;
  wire wrKey = bus.sfrWr && hitKey;
  wire anyAcc = bus.sfrWr || bus.sfrRd || bus.tblValid;
  wire [4:0] slot = bus.tblAddr[5:1];

  logic [15:0] ctrl_q;
  logic [15:0] adrL_q;
  logic [7:0] adrHLo_q;
  logic [15:0] rdata_q;
  logic stall_q;
  logic [23:0] rowAddr_q;
  logic erase_q;
  logic [31:0] cnt_q;
  pfs_key_t key_q, key_d;
  pfs_seq_t seq_q;
  logic [15:0] lowLatch_q [ROW_WORDS];
  logic [7:0] highLatch_q [ROW_WORDS];

  wire startReq = wrCtrl && bus.sfrWdata[BIT_START] && ctrl_q[BIT_ALLOW];
  // only an armed key opens the start
  wire launch = startReq && (key_q == KEY_ARMED) && (seq_q == SEQ_IDLE);

  // -----------------------------------------
  // unlock key sequencer
  // -----------------------------------------
  always_comb begin
    key_d = key_q;
    case (key_q)
      KEY_IDLE: begin
        if (wrKey && bus.sfrWdata[7:0] == KEY_FIRST) begin
          key_d = KEY_GOT55;
        end
      end
      KEY_GOT55: begin
        if (wrKey && bus.sfrWdata[7:0] == KEY_SECOND) begin
          key_d = KEY_ARMED;
        end else if (anyAcc) begin
          key_d = KEY_IDLE;
        end
      end
      // any access consumes the armed state
      KEY_ARMED: begin
        if (anyAcc) begin
          key_d = KEY_IDLE;
        end
      end
      default: key_d = KEY_IDLE;
    endcase
  end

  // -----------------------------------------
  // registers
  // -----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_q <= KEY_IDLE;
    end else begin
      key_q <= key_d;
    end
  end

  // control reset, address low and high bytes left alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      // software writes the other bits, start bit only sets
      if (wrCtrl) begin
        ctrl_q <= (bus.sfrWdata & CTRL_IMPL & 16'h7fff) | {ctrl_q[BIT_START] | launch, 15'h0000};
      end
      if (seq_q == SEQ_DONE) begin
        ctrl_q[BIT_START] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    // capture of effective address on table access
    if (bus.tblValid) begin
      adrL_q <= bus.tblAddr[15:0];
      adrHLo_q <= bus.tblAddr[23:16];
    // direct software write of the address
    end else if (bus.sfrWr && hitAdrL) begin
      adrL_q <= bus.sfrWdata;
    end else if (bus.sfrWr && hitAdrH) begin
      adrHLo_q <= bus.sfrWdata[7:0];
    end
  end

  // table writes fill the row latches by slot
  generate
    for (genvar i = 0; i < ROW_WORDS; i++) begin : g_latch
      wire hit = bus.tblValid && bus.tblWrite && (slot == 5'(i));
      always_ff @(posedge clk) begin
        if (hit && !bus.tblHigh) begin
          lowLatch_q[i] <= bus.tblData;
        end
        if (hit && bus.tblHigh) begin
          highLatch_q[i] <= bus.tblData[7:0];
        end
        if (sys_rst) begin
          rowImage[i*24 +: 24] <= 24'h000000;
        end else if (seq_q == SEQ_DONE) begin
          rowImage[i*24 +: 24] <= {highLatch_q[i], lowLatch_q[i]};
        end
      end
    end
  endgenerate

  // -----------------------------------------
  // operation sequencer
  // -----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_q <= SEQ_IDLE;
      cnt_q <= 32'h00000000;
      stall_q <= 1'b0;
      rowAddr_q <= 24'h000000;
      erase_q <= 1'b0;
      opDone <= 1'b0;
    end else begin
      opDone <= 1'b0;
      case (seq_q)
        SEQ_IDLE: begin
          if (launch) begin
            seq_q <= SEQ_BUSY;
            cnt_q <= 32'(OP_CNT - 1);
            stall_q <= 1'b1;
            rowAddr_q <= {adrHLo_q, adrL_q[15:6], 6'h00};
            erase_q <= ctrl_q[6];
          end
        end
        // hold stall for the whole count
        SEQ_BUSY: begin
          if (cnt_q == 32'h00000000) begin
            seq_q <= SEQ_DONE;
          end else begin
            cnt_q <= cnt_q - 32'h00000001;
          end
        end
        SEQ_DONE: begin
          stall_q <= 1'b0;
          opDone <= 1'b1;
          seq_q <= SEQ_IDLE;
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // -----------------------------------------
  // read path
  // -----------------------------------------
  // unimplemented bits and key read zero
  wire [15:0] rdMux = hitCtrl ? (ctrl_q & CTRL_IMPL) :
                      hitAdrL ? adrL_q :
                      hitAdrH ? {8'h00, adrHLo_q} : 16'h0000;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
      ctrlView <= CTRL_RST;
    end else begin
      if (bus.sfrRd) begin
        rdata_q <= rdMux;
      end
      ctrlView <= ctrl_q & CTRL_IMPL;
    end
  end

  assign bus.sfrRdata = rdata_q;
  assign bus.cpuStall = stall_q;
  assign opBusy = stall_q;
  assign opErase = erase_q;
  assign opRowAddr = rowAddr_q;
endmodule : pfs_row_sequencer
`default_nettype wire

// File: verif/pfs_checker_assertions.sv
// checker: sfr bus and stall properties of the flash row sequencer
`timescale 1ns/1ps
`default_nettype none
module pfs_checker
  import pfs_pkg::*;
#(
  parameter int OP_CNT = 20
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [15:0] sfrAddr,
  input wire logic [15:0] sfrWdata,
  input wire logic [15:0] sfrRdata,
  input wire logic tblValid,
  input wire logic [23:0] tblAddr,
  input wire logic cpuStall
);
  // ---------------------------
  // helper logic
  // ---------------------------
  logic [31:0] stallCnt_q;
  logic [15:0] expLo_q;
  logic [7:0] expHi_q;
  logic known_q;
  wire logic startWr = sfrWr && sfrAddr == OFS_CTRL && sfrWdata[BIT_START];
  wire logic key1Wr = sfrWr && sfrAddr == OFS_KEY && sfrWdata[7:0] == KEY_FIRST;
  wire logic key2Wr = sfrWr && sfrAddr == OFS_KEY && sfrWdata[7:0] == KEY_SECOND;
  wire logic rdLo = sfrRd && sfrAddr == OFS_ADRL && known_q;
  wire logic rdHi = sfrRd && sfrAddr == OFS_ADRH && known_q;
  // address model only trusted once a table access has set both halves
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stallCnt_q <= '0;
      known_q <= 1'b0;
    end else begin
      stallCnt_q <= cpuStall ? stallCnt_q + 32'h1 : 32'h0;
      if (tblValid) begin
        known_q <= 1'b1;
        expLo_q <= tblAddr[15:0];
        expHi_q <= tblAddr[23:16];
      end else if (sfrWr && sfrAddr == OFS_ADRL) begin
        expLo_q <= sfrWdata;
      end else if (sfrWr && sfrAddr == OFS_ADRH) begin
        expHi_q <= sfrWdata[7:0];
      end
    end
  end
  // ---------------------------
  // properties
  // ---------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  stall_len_a: assert property ($fell(cpuStall) |-> stallCnt_q == OP_CNT + 1)
    else $error("stall length wrong");
  stall_hold_a: assert property ($rose(cpuStall) |=> cpuStall [*8])
    else $error("stall dropped early");
  launch_key_a: assert property ($rose(cpuStall) |->
    $past(startWr) && $past(key2Wr, 2) && $past(key1Wr, 3))
    else $error("operation began without key and start");
  key_read_a: assert property (sfrRd && sfrAddr == OFS_KEY |=> sfrRdata == 16'h0000)
    else $error("key register read not zero");
  ctrl_unimpl_a: assert property (sfrRd && sfrAddr == OFS_CTRL |=>
    (sfrRdata & ~CTRL_IMPL) == 16'h0000)
    else $error("control unimplemented bits not zero");
  start_clear_a: assert property (sfrRd && sfrAddr == OFS_CTRL |=> !sfrRdata[BIT_START])
    else $error("start bit seen set outside operation");
  adrl_read_a: assert property (rdLo |=> sfrRdata == expLo_q)
    else $error("low address readback wrong");
  adrh_read_a: assert property (rdHi |=> sfrRdata == {8'h00, expHi_q})
    else $error("upper address readback wrong");
  rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> !cpuStall && sfrRdata == 16'h0000)
    else $error("reset state wrong");
  cover property ($fell(cpuStall));
  cover property (rdLo);
  cover property (key2Wr);
endmodule : pfs_checker
`default_nettype wire

// File: verif/tb_program_flash_row_sequencer.sv
// testbench: both ends of the flash row sequencer joined by the interface
`timescale 1ns/1ps
`default_nettype none
module tb_program_flash_row_sequencer;
  import pfs_pkg::*;
  localparam int OPC = 20;
  logic clk, sys_rst, reqRegWr, reqRegRd, reqUnlockStart, reqTblWr, reqTblHigh;
  logic [23:0] reqAddr, base, ta;
  logic [15:0] reqData, a, b;
  logic [15:0] lo [32];
  logic [15:0] hi [32];
  logic reqReady, rdValid, opBusy, opDone, opErase;
  logic [15:0] rdData, ctrlView;
  logic [23:0] opRowAddr;
  logic [ROW_BYTES*8-1:0] rowImage;
  int err_count, n_compared, seed, n;
  pfs_if busIf();
  pfs_core_host pfs_core_host_i (.clk(clk), .sys_rst(sys_rst), .bus(busIf),
    .reqRegWr(reqRegWr), .reqRegRd(reqRegRd), .reqUnlockStart(reqUnlockStart),
    .reqTblWr(reqTblWr), .reqTblHigh(reqTblHigh), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid));
  pfs_row_sequencer #(.OP_CNT(OPC)) pfs_row_sequencer_i (.clk(clk), .sys_rst(sys_rst),
    .bus(busIf), .opBusy(opBusy), .opDone(opDone), .opErase(opErase),
    .opRowAddr(opRowAddr), .rowImage(rowImage), .ctrlView(ctrlView));
  pfs_checker #(.OP_CNT(OPC)) pfs_checker_i (.clk(clk), .sys_rst(sys_rst),
    .sfrWr(busIf.sfrWr), .sfrRd(busIf.sfrRd), .sfrAddr(busIf.sfrAddr),
    .sfrWdata(busIf.sfrWdata), .sfrRdata(busIf.sfrRdata), .tblValid(busIf.tblValid),
    .tblAddr(busIf.tblAddr), .cpuStall(busIf.cpuStall));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ---------------------------
  // tasks
  // ---------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // k = {wr, rd, tbl, high, unlock}; held until the edge that takes it
  task automatic req(input logic [4:0] k, input logic [23:0] ad, input logic [15:0] d);
    while (reqReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    {reqRegWr, reqRegRd, reqTblWr, reqTblHigh, reqUnlockStart} = k;
    reqAddr = ad;
    reqData = d;
    @(posedge clk);
    #1 {reqRegWr, reqRegRd, reqTblWr, reqTblHigh, reqUnlockStart} = 5'h00;
  endtask : req
  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    req(5'h10, {8'h00, ad}, d);
  endtask : wr
  task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
    req(5'h08, {8'h00, ad}, 16'h0000);
    for (int i = 0; i < 20 && rdValid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({8'h00, rdData}, {8'h00, exp});
  endtask : rd
  // counts stalled cycles up to the done pulse
  task automatic run_op();
    n = 0;
    req(5'h01, 24'h000000, 16'h0000);
    for (int k = 0; k < 200 && opDone !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      if (busIf.cpuStall === 1'b1) n++;
    end
    chk(24'(n), 24'(OPC + 1));
  endtask : run_op
  // readback of a control write: unimplemented bits and start bit drop out
  function automatic logic [15:0] ctrl_exp(input logic [15:0] w);
    return w & CTRL_IMPL & 16'h7fff;
  endfunction : ctrl_exp
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  initial begin
    #(25 * 20000);
    err_count++;
    conclude();
  end
  // ---------------------------
  // scenarios
  // ---------------------------
  initial begin
    {sys_rst, reqRegWr, reqRegRd, reqUnlockStart, reqTblWr, reqTblHigh} = 6'h20;
    reqAddr = 24'h000000;
    reqData = 16'h0000;
    err_count = 0;
    n_compared = 0;
    seed = 89;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_KEY, 16'h0000);
    rd(16'h0768, 16'h0000);
    base = 24'($random(seed)) & 24'hffffc0;
    for (int i = 0; i < 32; i++) begin
      lo[i] = 16'($random(seed));
      hi[i] = (i == 0) ? 16'hff00 : 16'($random(seed));
      ta = base + 24'(2 * i);
      req(5'h04, ta, lo[i]);
      req(5'h06, ta, hi[i]);
    end
    rd(OFS_ADRL, ta[15:0]);
    rd(OFS_ADRH, {8'h00, ta[23:16]});
    wr(OFS_CTRL, 16'h4001);
    run_op();
    chk({23'h0, opErase}, 24'h000000);
    chk(opRowAddr, base);
    for (int i = 0; i < 32; i++) begin
      chk(rowImage[i*24+:24], {hi[i][7:0], lo[i]});
    end
    rd(OFS_CTRL, 16'h4001);
    for (int j = 0; j < 4; j++) begin
      a = (j == 3) ? 16'hffff : 16'($random(seed));
      b = 16'($random(seed));
      wr(OFS_ADRL, a);
      rd(OFS_ADRL, a);
      wr(OFS_ADRH, b);
      rd(OFS_ADRH, {8'h00, b[7:0]});
    end
    wr(OFS_CTRL, CTRL_ROW_ERASE);
    run_op();
    chk({23'h0, opErase}, 24'h000001);
    chk(opRowAddr, {b[7:0], a} & 24'hffffc0);
    wr(OFS_CTRL, 16'h7fff);
    rd(OFS_CTRL, ctrl_exp(16'h7fff));
    chk({8'h00, ctrlView}, {8'h00, ctrl_exp(16'h7fff)});
    wr(OFS_CTRL, 16'hffff);
    // a wrongful launch would show its stall only after the device sees the write
    repeat (3) @(posedge clk);
    #1;
    chk({23'h0, busIf.cpuStall}, 24'h000000);
    rd(OFS_CTRL, ctrl_exp(16'hffff));
    wr(OFS_CTRL, 16'h4001);
    wr(OFS_KEY, 16'h0055);
    rd(OFS_CTRL, 16'h4001);
    wr(OFS_KEY, 16'h00aa);
    wr(OFS_CTRL, 16'hc001);
    repeat (3) @(posedge clk);
    #1;
    chk({23'h0, busIf.cpuStall}, 24'h000000);
    rd(OFS_KEY, 16'h0000);
    conclude();
  end
endmodule : tb_program_flash_row_sequencer
`default_nettype wire
